// ===== core/rsq_defs.vh
`ifndef RSQ_DEFS_VH
`define RSQ_DEFS_VH
// ****************************************
// register map (byte addresses, one word each)
// ****************************************
`define RSQ_ADDR_CAUSE 8'h00
`define RSQ_ADDR_OPTION 8'h04
`define RSQ_ADDR_INTEN 8'h08
`define RSQ_ADDR_STATUS 8'h0c
`define RSQ_ADDR_PRESCALE 8'h10
// ****************************************
// cause register fields
// ****************************************
`define RSQ_CAUSE_POR 5
`define RSQ_CAUSE_PIN 4
`define RSQ_CAUSE_WDOG 3
`define RSQ_CAUSE_ILLEGAL_OPCODE_FLAG 2
`define RSQ_CAUSE_ILLEGAL_ADDRESS_FLAG 1
`define RSQ_CAUSE_UV 0
// ****************************************
// option register fields and reset value
// ****************************************
`define RSQ_OPT_STOP_EN 0
`define RSQ_OPT_SHORT_REC 1
`define RSQ_OPTION_RESET 2'h0
// ****************************************
// timing, in oscillator reference cycles; the divider is in clock cycles
// ****************************************
`define RSQ_LONG_DELAY 13'h1000
`define RSQ_SHORT_DELAY 13'h0020
`define RSQ_PIN_LOW_CYCLES 7'h20
`define RSQ_RELEASE_CYCLES 7'h40
`define RSQ_OSC_DIV 8'h08
// ****************************************
// vectors
// ****************************************
`define RSQ_VEC_BASE 16'hffd0
`define RSQ_VEC_SWI 16'hfffc
`define RSQ_VEC_RESET 16'hfffe
`endif

// ===== core/rsq_arbiter.v
`include "rsq_defs.vh"
// fixed-priority interrupt latch; higher index wins, holds until clear_i or rst_i
module rsq_arbiter #(
  parameter N = 22
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // control
  input wire sample_i,
  input wire clear_i,
  input wire [N-1:0] req_i,
  // result
  output reg valid_o,
  output reg [4:0] code_o
);

  // highest set index
  function [4:0] rsq_top;
    input [N-1:0] v;
    integer k;
    begin
      rsq_top = 5'h00;
      for (k = 0; k < N; k = k + 1) begin
        if (v[k]) begin
          rsq_top = k[4:0];
        end
      end
    end
  endfunction

  // a latched choice is never displaced by a later, higher request
  always @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      valid_o <= 1'b0;
      code_o <= 5'h00;
    end else if (sample_i && !valid_o && (|req_i)) begin
      valid_o <= 1'b1;
      code_o <= rsq_top(req_i);
    end
  end

endmodule // rsq_arbiter

// ===== core/rsq_sequencer.v
`include "rsq_defs.vh"
// Function
// RULE1: illegal instruction sets illegal opcode flag and starts internal reset.
// RULE2: stop with stop-enable clear counts as illegal opcode.
// RULE3: every internal reset cause drives external reset pin low.
// RULE4: opcode fetch from unmapped address sets illegal address flag and resets; code leaves it clear when an illegal opcode is flagged in the same cycle.
// RULE5: data read from unmapped address causes nothing.
// RULE6: undervoltage: pin low 4096 ref cycles, CPU released 64 later.
// RULE7: prescale counter is 13 bits, advancing on ref clock falling edge.
// RULE8: each prescale overflow gives one watchdog clock event.
// RULE9: bus clocks stay off until stabilization interval timed out.
// RULE10: stop instruction clears prescale counter.
// RULE11: stop wake uses 32 cycles if short recovery set, else 4096.
// RULE12: external reset pin leaves prescale counter unchanged.
// RULE13: after any reset sequence the prescale counter free-runs.
// RULE14: power-on pulse: initialise first, then enable clock generation output.
// RULE15: interrupt entry stacks registers and sets mask; return unstacks.
// RULE16: pending interrupts latched, arbitrated, vector code given to CPU.
// RULE17: latched interrupt not replaced until serviced or mask cleared; code also clears it when a software trap is taken first.
// RULE18: interrupts taken only at instruction end, unmasked and enabled.
// RULE19: highest pending first; pending at return taken before next instruction.
// RULE20: interrupt entry does not stack index high register; software saves it.
// RULE21: software trap ignores mask and stacks PC, hardware stacks PC minus one.
// RULE22: vectors pairs from ffd0 upward, priority rising; reset fffe highest.
// RULE23: all resets share top priority and bypass interrupt arbitration.
// RULE24: unmapped decode is a config input sampled on opcode-fetch cycle.
module rsq_sequencer #(
  parameter NIRQ = 22,
  parameter LONG_DELAY = `RSQ_LONG_DELAY
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // reset sources (asynchronous)
  input wire por_pulse_i,
  input wire undervoltage_i,
  input wire ext_reset_n_i,
  input wire wdog_reset_i,
  // cpu status
  input wire illegal_opcode_i,
  input wire stop_exec_i,
  input wire opcode_fetch_i,
  input wire unmapped_i,
  input wire instr_done_i,
  input wire mask_bit_i,
  input wire swi_exec_i,
  input wire rti_exec_i,
  input wire wake_i,
  input wire [NIRQ-1:0] irq_i,
  // outputs
  output reg ext_reset_o,
  output reg ext_reset_oe_o,
  output reg cpu_reset_o,
  output reg bus_clk_en_o,
  output reg clkgen_en_o,
  output reg wdog_tick_o,
  output reg irq_take_o,
  output reg stack_pc_minus1_o,
  output reg set_mask_o,
  output reg unstack_o,
  output reg [15:0] vector_o
);

  // ****************************************
  // state codes
  // ****************************************
  localparam S_RUN = 3'h0;
  localparam S_INIT = 3'h1;
  localparam S_LONG = 3'h2;
  localparam S_PIN = 3'h3;
  localparam S_REL = 3'h4;
  localparam S_STOP = 3'h5;
  localparam S_REC = 3'h6;

  // ****************************************
  // input synchronisers
  // ****************************************
  reg [4:0] sync1;
  reg [4:0] sync2;
  // first stage feeds only the second
  always @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= 5'h04;
      sync2 <= 5'h04;
    end else begin
      sync1 <= {wdog_reset_i, undervoltage_i, ext_reset_n_i, por_pulse_i, 1'b0};
      sync2 <= sync1;
    end
  end
  wire por_s = sync2[1];
  wire pin_n_s = sync2[2];
  wire uv_s = sync2[3];
  wire wdog_s = sync2[4];

  // ****************************************
  // oscillator reference falling-edge enable
  // ****************************************
  reg [7:0] div;
  reg osc_fall;
  // one-cycle pulse marks each falling edge of the reference clock
  always @(posedge clk_i) begin
    if (rst_i) begin
      div <= 8'h00;
      osc_fall <= 1'b0;
    end else begin
      osc_fall <= (div == `RSQ_OSC_DIV - 8'h01);
      if (div == `RSQ_OSC_DIV - 8'h01) begin
        div <= 8'h00;
      end else begin
        div <= div + 8'h01;
      end
    end
  end

  // ****************************************
  // sequencer state and prescale counter
  // ****************************************
  reg [2:0] state;
  reg [12:0] pcount;
  reg [6:0] seqcnt;
  reg [12:0] rec_len;
  reg [5:0] cause;
  reg [1:0] option;
  reg [NIRQ-1:0] int_en;
  reg long_pending;

  // internal reset causes, resets bypass arbitration
  // RULE2: stop treated illegal
  wire stop_bad = stop_exec_i && !option[`RSQ_OPT_STOP_EN];
  // RULE24: fetch decode sampled
  wire illegal_address_flag_ev = opcode_fetch_i && unmapped_i;
  wire run = (state == S_RUN);
  // RULE23: no arbitration for resets
  wire int_cause = run && (illegal_opcode_i || stop_bad || illegal_address_flag_ev || wdog_s);
  wire long_cause = por_s || uv_s;

  // counter, state and cause flags
  always @(posedge clk_i) begin
    if (rst_i) begin
      state <= S_INIT;
      pcount <= 13'h0000;
      seqcnt <= 7'h00;
      rec_len <= LONG_DELAY;
      cause <= 6'h20;
      long_pending <= 1'b1;
      wdog_tick_o <= 1'b0;
    end else begin
      wdog_tick_o <= 1'b0;
      // RULE7: count falling edges
      // RULE13: free-running otherwise
      // RULE12: pin reset never touches it
      if (osc_fall && state != S_STOP) begin
        pcount <= pcount + 13'h0001;
        // RULE8: overflow clocks watchdog
        if (pcount == 13'h1fff) begin
          wdog_tick_o <= 1'b1;
        end
      end
      // a long cause also restarts a stop recovery, never a running power-on count
      if (long_cause && state != S_INIT && !(state == S_LONG && long_pending)) begin
        // RULE14: init before clocks
        // RULE6: undervoltage sequence
        state <= S_INIT;
        long_pending <= 1'b1;
        if (por_s) begin
          cause <= 6'h20;
        end else begin
          cause <= 6'h01;
        end
      end else begin
        case (state)
          S_INIT: begin
            pcount <= 13'h0000;
            rec_len <= LONG_DELAY;
            state <= S_LONG;
          end
          S_LONG: begin
            // RULE9: wait stabilization interval
            if (pcount >= rec_len - 13'h0001 && osc_fall) begin
              seqcnt <= 7'h00;
              if (long_pending) begin
                state <= S_REL;
              end else begin
                state <= S_RUN;
              end
              long_pending <= 1'b0;
            end
          end
          S_PIN: begin
            if (osc_fall) begin
              seqcnt <= seqcnt + 7'h01;
              if (seqcnt == `RSQ_PIN_LOW_CYCLES - 7'h01) begin
                seqcnt <= 7'h00;
                state <= S_REL;
              end
            end
          end
          S_REL: begin
            if (osc_fall) begin
              seqcnt <= seqcnt + 7'h01;
              if (seqcnt == `RSQ_RELEASE_CYCLES - 7'h01) begin
                state <= S_RUN;
              end
            end
          end
          S_STOP: begin
            if (wake_i) begin
              // RULE11: pick recovery length
              if (option[`RSQ_OPT_SHORT_REC]) begin
                rec_len <= `RSQ_SHORT_DELAY;
              end else begin
                rec_len <= LONG_DELAY;
              end
              state <= S_LONG;
            end
          end
          S_RUN: begin
            if (int_cause) begin
              // RULE1: illegal opcode reset
              // RULE4: illegal address reset
              // RULE5: data reads ignored
              cause[`RSQ_CAUSE_WDOG] <= wdog_s;
              cause[`RSQ_CAUSE_ILLEGAL_OPCODE_FLAG] <= illegal_opcode_i || stop_bad;
              cause[`RSQ_CAUSE_ILLEGAL_ADDRESS_FLAG] <= illegal_address_flag_ev && !(illegal_opcode_i || stop_bad);
              cause[`RSQ_CAUSE_POR] <= 1'b0;
              cause[`RSQ_CAUSE_PIN] <= 1'b0;
              cause[`RSQ_CAUSE_UV] <= 1'b0;
              seqcnt <= 7'h00;
              pcount <= 13'h0000;
              state <= S_PIN;
            end else if (!pin_n_s) begin
              cause <= 6'h10;
            end else if (stop_exec_i) begin
              // RULE10: stop clears counter
              pcount <= 13'h0000;
              state <= S_STOP;
            end else if (wb_ack_o && !wb_we_i && wb_adr_i == `RSQ_ADDR_CAUSE) begin
              cause <= 6'h00;
            end
          end
          default: begin
            state <= S_INIT;
          end
        endcase
      end
    end
  end

  // ****************************************
  // pin and clock outputs
  // ****************************************
  // RULE3: pin driven low
  always @(posedge clk_i) begin
    if (rst_i) begin
      ext_reset_o <= 1'b0;
      ext_reset_oe_o <= 1'b1;
      cpu_reset_o <= 1'b1;
      bus_clk_en_o <= 1'b0;
      clkgen_en_o <= 1'b0;
    end else begin
      ext_reset_o <= 1'b0;
      ext_reset_oe_o <= (state == S_LONG && long_pending) || state == S_PIN || state == S_INIT;
      cpu_reset_o <= !(state == S_RUN || state == S_STOP || (state == S_LONG && !long_pending));
      bus_clk_en_o <= (state == S_RUN);
      clkgen_en_o <= (state != S_INIT && state != S_STOP);
    end
  end

  // ****************************************
  // interrupt arbitration
  // ****************************************
  wire lat_valid;
  wire [4:0] lat_code;
  // RULE18: unmasked, enabled, at instruction end
  wire sample = run && instr_done_i && !mask_bit_i && !irq_take_o;
  // RULE17: cleared on any take, so a software trap taken the cycle after latching clears it unserviced
  wire lat_clear = irq_take_o;
  rsq_arbiter #(
    .N(NIRQ)
  ) u_arb (
    .clk_i(clk_i),
    .rst_i(rst_i || !run),
    .sample_i(sample),
    .clear_i(lat_clear),
    .req_i(irq_i & int_en),
    .valid_o(lat_valid),
    .code_o(lat_code)
  );

  // RULE15: stack and mask on entry
  // RULE16: vector from latched code
  // RULE19: re-sampled after each return
  // RULE21: trap ignores mask, stacks pc
  // RULE22: vector pairs rise from base
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_take_o <= 1'b0;
      stack_pc_minus1_o <= 1'b0;
      set_mask_o <= 1'b0;
      unstack_o <= 1'b0;
      vector_o <= `RSQ_VEC_RESET;
    end else begin
      irq_take_o <= 1'b0;
      set_mask_o <= 1'b0;
      unstack_o <= run && rti_exec_i;
      if (!run) begin
        vector_o <= `RSQ_VEC_RESET;
      end else if (swi_exec_i) begin
        irq_take_o <= 1'b1;
        set_mask_o <= 1'b1;
        stack_pc_minus1_o <= 1'b0;
        vector_o <= `RSQ_VEC_SWI;
      end else if (lat_valid && !irq_take_o) begin
        irq_take_o <= 1'b1;
        set_mask_o <= 1'b1;
        stack_pc_minus1_o <= 1'b1;
        vector_o <= `RSQ_VEC_BASE + {10'h000, lat_code, 1'b0};
      end
    end
  end

  // ****************************************
  // wishbone registers
  // ****************************************
  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      option <= `RSQ_OPTION_RESET;
      int_en <= {NIRQ{1'b0}};
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && wb_we_i && wb_sel_i[0]) begin
        if (wb_adr_i == `RSQ_ADDR_OPTION) begin
          option <= wb_dat_i[1:0];
        end
        if (wb_adr_i == `RSQ_ADDR_INTEN) begin
          int_en <= wb_dat_i[NIRQ-1:0];
        end
      end
      case (wb_adr_i)
        `RSQ_ADDR_CAUSE: wb_dat_o <= {26'h0000000, cause};
        `RSQ_ADDR_OPTION: wb_dat_o <= {30'h00000000, option};
        `RSQ_ADDR_INTEN: wb_dat_o <= {{(32-NIRQ){1'b0}}, int_en};
        `RSQ_ADDR_STATUS: wb_dat_o <= {23'h000000, lat_valid, lat_code, state};
        `RSQ_ADDR_PRESCALE: wb_dat_o <= {19'h00000, pcount};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

endmodule // rsq_sequencer

// ===== verif/rsq_sequencer_props.sv
// ****************************************
// port checker for the sequencer
// ****************************************
module rsq_sequencer_props (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // cpu status
  input wire logic illegal_opcode_i,
  input wire logic opcode_fetch_i,
  input wire logic unmapped_i,
  input wire logic swi_exec_i,
  // watched outputs
  input wire logic ext_reset_o,
  input wire logic ext_reset_oe_o,
  input wire logic cpu_reset_o,
  input wire logic wdog_tick_o,
  input wire logic irq_take_o,
  input wire logic set_mask_o,
  input wire logic stack_pc_minus1_o,
  input wire logic [15:0] vector_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_illegal_opcode_flag; illegal_opcode_i && !cpu_reset_o |-> ##[1:3] ext_reset_oe_o; endproperty
  property p_illegal_address_flag; opcode_fetch_i && unmapped_i && !cpu_reset_o |-> ##[1:3] ext_reset_oe_o; endproperty
  property p_pin_low; ext_reset_oe_o |-> ext_reset_o == 1'b0; endproperty
  property p_pin_len; $rose(ext_reset_oe_o) |=> (ext_reset_oe_o && cpu_reset_o)[*8]; endproperty
  property p_release; $fell(ext_reset_oe_o) |-> cpu_reset_o[*8]; endproperty
  property p_swi; swi_exec_i && !cpu_reset_o
    |-> ##[1:2] (irq_take_o && vector_o == 16'hfffc && !stack_pc_minus1_o); endproperty
  property p_entry; irq_take_o |-> set_mask_o; endproperty
  property p_hw_vec; irq_take_o && stack_pc_minus1_o
    |-> vector_o >= 16'hffd0 && vector_o <= 16'hfffa && !vector_o[0]; endproperty
  property p_no_irq_rst; cpu_reset_o |-> !irq_take_o; endproperty
  property p_tick; wdog_tick_o |=> !wdog_tick_o; endproperty
  a_illegal_opcode_flag: assert property (p_illegal_opcode_flag) else $error("no pin drive after bad opcode");
  a_illegal_address_flag: assert property (p_illegal_address_flag) else $error("no pin drive after bad fetch");
  a_pin_low: assert property (p_pin_low) else $error("pin driven high");
  a_pin_len: assert property (p_pin_len) else $error("pin drive too short");
  a_release: assert property (p_release) else $error("cpu released early");
  a_swi: assert property (p_swi) else $error("software trap entry wrong");
  a_entry: assert property (p_entry) else $error("entry without mask set");
  a_hw_vec: assert property (p_hw_vec) else $error("hardware vector out of range");
  a_no_irq_rst: assert property (p_no_irq_rst) else $error("interrupt during reset");
  a_tick: assert property (p_tick) else $error("watchdog tick too long");
  c_hw: cover property (irq_take_o && stack_pc_minus1_o);
  c_swi: cover property (irq_take_o && !stack_pc_minus1_o);
  c_rst: cover property ($rose(ext_reset_oe_o));
endmodule // rsq_sequencer_props
bind rsq_sequencer rsq_sequencer_props i_rsq_sequencer_props (.clk_i, .rst_i,
  .illegal_opcode_i, .opcode_fetch_i, .unmapped_i, .swi_exec_i, .ext_reset_o,
  .ext_reset_oe_o, .cpu_reset_o, .wdog_tick_o, .irq_take_o, .set_mask_o,
  .stack_pc_minus1_o, .vector_o);

// ===== verif/rsq_cpu_model.sv
// ****************************************
// cpu core stand-in
// ****************************************
module rsq_cpu_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // from sequencer
  input wire logic cpu_reset_i,
  input wire logic bus_clk_en_i,
  input wire logic set_mask_i,
  // to sequencer
  output logic instr_done_o,
  output logic mask_bit_o,
  output logic rti_exec_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic mask;
  logic [4:0] svc;
  logic [1:0] cnt;
  // mask at entry: shown at once so a still-high source cannot relatch
  assign mask_bit_o = mask | set_mask_i;
  // entry sets mask, return clears; no index register is kept
  always @(posedge clk_i) begin
    instr_done_o <= 1'b0;
    rti_exec_o <= 1'b0;
    if (rst_i || cpu_reset_i) begin
      mask <= 1'b0;
      svc <= 5'h0;
      cnt <= 2'h0;
    end else if (bus_clk_en_i) begin
      cnt <= cnt + 2'h1;
      instr_done_o <= (cnt == 2'h3);
      if (set_mask_i) begin
        mask <= 1'b1;
        svc <= 5'h14;
      end else if (svc == 5'h1) begin
        rti_exec_o <= 1'b1;
        mask <= 1'b0;
        svc <= 5'h0;
      end else if (svc != 5'h0) begin
        svc <= svc - 5'h1;
      end
    end
  end
endmodule // rsq_cpu_model

// ===== verif/rsq_sequencer_tb.sv
`include "rsq_defs.vh"
module rsq_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, por_pulse_i, undervoltage_i;
  logic ext_reset_n_i, wdog_reset_i, illegal_opcode_i, stop_exec_i, opcode_fetch_i;
  logic unmapped_i, instr_done_i, mask_bit_i, swi_exec_i, rti_exec_i, wake_i, ext_reset_o;
  logic ext_reset_oe_o, cpu_reset_o, bus_clk_en_o, clkgen_en_o, wdog_tick_o, irq_take_o;
  logic stack_pc_minus1_o, set_mask_o, unstack_o, rti_seen;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [21:0] irq_i;
  logic [15:0] vector_o;
  logic [31:0] q_rd[$];
  logic [16:0] q_vec[$];
  int fail_count = 0, compares = 0, cycles = 0, seed = 32'h1486, a, b, n, e;
  int bits[7] = '{2, 1, 2, 0, 3, 4, 5};
  rsq_sequencer #(.NIRQ(22), .LONG_DELAY(13'h0040)) i_rsq_sequencer (.clk_i, .rst_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .por_pulse_i, .undervoltage_i, .ext_reset_n_i, .wdog_reset_i, .illegal_opcode_i,
    .stop_exec_i, .opcode_fetch_i, .unmapped_i, .instr_done_i, .mask_bit_i, .swi_exec_i,
    .rti_exec_i, .wake_i, .irq_i, .ext_reset_o, .ext_reset_oe_o, .cpu_reset_o,
    .bus_clk_en_o, .clkgen_en_o, .wdog_tick_o, .irq_take_o, .stack_pc_minus1_o,
    .set_mask_o, .unstack_o, .vector_o);
  rsq_cpu_model i_rsq_cpu_model (.clk_i, .rst_i, .cpu_reset_i(cpu_reset_o),
    .bus_clk_en_i(bus_clk_en_o), .set_mask_i(set_mask_o), .instr_done_o(instr_done_i),
    .mask_bit_o(mask_bit_i), .rti_exec_o(rti_exec_i));
  // ****************************************
  // clock, timeout and checking helpers
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, x, g);
    end
  endtask
  task report_and_stop;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      fail_count++;
      report_and_stop;
    end
  end
  // monitor: every answer takes the oldest note
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) chk("read data", q_rd.pop_front(), wb_dat_o);
    rti_seen <= rti_exec_i;
    if (rti_seen === 1'b1 || unstack_o === 1'b1) chk("unstack", rti_seen, unstack_o);
    if (irq_take_o === 1'b1) chk("vector", q_vec.pop_front(), {stack_pc_minus1_o, vector_o});
  end
  // classic single cycle; waits for ack, never assumes its delay
  task automatic wb(input logic we, input logic [7:0] ad, input logic [31:0] d);
    if (!we) q_rd.push_back(d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= ad;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  function automatic logic sig(input int w);
    return w == 0 ? cpu_reset_o : (w == 1 ? ext_reset_oe_o : bus_clk_en_o);
  endfunction
  task automatic wait_sig(input int w, input logic v, input int lim);
    n = 0;
    while (sig(w) !== v && n < lim) begin @(posedge clk_i); n++; end
    if (n == lim) chk("wait", v, sig(w));
  endtask
  task automatic wait_q(input int m);
    n = 0;
    while (q_vec.size() > m && n < 500) begin @(posedge clk_i); n++; end
    if (n == 500) chk("interrupt take", m, q_vec.size());
  endtask
  task automatic hit(input int k);
    case (k)
      0: illegal_opcode_i <= 1'b1;
      1: {opcode_fetch_i, unmapped_i} <= 2'h3;
      2: stop_exec_i <= 1'b1;
      3: undervoltage_i <= 1'b1;
      4: wdog_reset_i <= 1'b1;
      5: ext_reset_n_i <= 1'b0;
      default: por_pulse_i <= 1'b1;
    endcase
    repeat (k < 3 ? 1 : (k == 5 ? 600 : 4)) @(posedge clk_i);
    {illegal_opcode_i, opcode_fetch_i, unmapped_i, stop_exec_i} <= 4'h0;
    {undervoltage_i, wdog_reset_i, por_pulse_i, ext_reset_n_i} <= 4'h1;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = {4'h8, 40'h0, 4'hf};
    {por_pulse_i, undervoltage_i, ext_reset_n_i, wdog_reset_i, irq_i} = {4'h2, 22'h0};
    {illegal_opcode_i, stop_exec_i, opcode_fetch_i, unmapped_i, swi_exec_i, wake_i} = 6'h0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_sig(0, 0, 3000);
    wb(0, `RSQ_ADDR_CAUSE, 32'h1 << `RSQ_CAUSE_POR);
    wb(0, `RSQ_ADDR_CAUSE, 32'h0);
    wb(0, 8'h20, 32'h0);
    wb(0, `RSQ_ADDR_STATUS, 32'h0);
    unmapped_i <= 1'b1;
    @(posedge clk_i);
    unmapped_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk("pin drive", 0, ext_reset_oe_o);
    wb(0, `RSQ_ADDR_CAUSE, 32'h0);
    for (int k = 0; k < 7; k++) begin
      hit(k);
      if (k != 5) wait_sig(1, 1, 20);
      wait_sig(0, 0, 3000);
      wb(0, `RSQ_ADDR_CAUSE, 32'h1 << bits[k]);
      chk("clock generation enable", 1, clkgen_en_o);
    end
    for (int s = 0; s < 2; s++) begin
      wb(1, `RSQ_ADDR_OPTION, s ? 32'h1 : 32'h3);
      wb(0, `RSQ_ADDR_OPTION, s ? 32'h1 : 32'h3);
      stop_exec_i <= 1'b1;
      @(posedge clk_i);
      stop_exec_i <= 1'b0;
      wait_sig(2, 0, 20);
      wb(0, `RSQ_ADDR_PRESCALE, 32'h0);
      repeat (20) @(posedge clk_i);
      wake_i <= 1'b1;
      @(posedge clk_i);
      wake_i <= 1'b0;
      wait_sig(2, 1, 1000);
      e = (s ? 64 : 32) * `RSQ_OSC_DIV;
      chk("stop recovery", 1, 32'(n > e - 24 && n < e + 24));
    end
    for (int i = 0; i < 4; i++) begin
      a = $unsigned($random(seed)) % 21;
      b = a + 1 + $unsigned($random(seed)) % (21 - a);
      wb(1, `RSQ_ADDR_INTEN, i[0] ? 32'h3fffff ^ (32'h1 << b) : 32'h3fffff);
      if (!i[0]) q_vec.push_back({1'b1, 16'hffd0 + 16'(2 * b)});
      q_vec.push_back({1'b1, 16'hffd0 + 16'(2 * a)});
      irq_i <= (22'h1 << a) | (22'h1 << b);
      wait_q(1);
      irq_i <= 22'h1 << a;
      wait_q(0);
      irq_i <= 22'h0;
    end
    q_vec.push_back({1'b0, `RSQ_VEC_SWI});
    swi_exec_i <= 1'b1;
    @(posedge clk_i);
    swi_exec_i <= 1'b0;
    wait_q(0);
    repeat (30) @(posedge clk_i);
    n = 0;
    while (wdog_tick_o !== 1'b1 && n < 70000) begin @(posedge clk_i); n++; end
    chk("watchdog tick", 1, wdog_tick_o);
    report_and_stop;
  end
endmodule // rsq_sequencer_tb
